/* File: hw/chip_clk_consts.svh */
// Operation
// R1: power-down entered only when request bit set and core then executes wait-for-interrupt
// R2: power-down held until an enabled wake-up interrupt fires, then left
// R3: fast oscillator is switched off on power-down entry
// R4: exactly two sources: fast 24 MHz and slow 10 kHz oscillators
// R5: enabling an oscillator starts its stable counter; terminal value sets stable flag
// R6: system and peripheral logic use an oscillator only while stable
// R7: clearing an oscillator enable clears its stable flag
// R8: enables at power control bits 3 and 2; stable flags at status 3, 4
// R9: system clock source chosen by clock select zero bits 2 to 0
// R10: tick external clock chosen by clock select zero bits 5 to 3
// R11: power-down gates system clocks; slow oscillator and its peripherals keep running
// R12: output divider is 16 divide-by-two stages with a sixteen-to-one selector
// R13: divided output equals input over two to the power N plus one
// R14: writing one to output enable bit 4 starts the divider
// R15: clearing output enable runs divider until selected clock low, then holds low
// R16: divide-by-one bit 5 bypasses the divider straight to the output pin
// R17: clock output pin does not toggle during power-down
// R18: unstable new system source is not taken until its stable flag is set
`ifndef CHIP_CLK_CONSTS_SVH
`define CHIP_CLK_CONSTS_SVH
`define FAST_OSC_KHZ      24000
`define SLOW_OSC_KHZ      10
`define FAST_STB_CYC_DEF  256
`define SLOW_STB_CYC_DEF  64
`define STB_CNT_W         16
`define OFS_PWR           8'h00
`define OFS_STATUS        8'h04
`define OFS_SEL0          8'h08
`define OFS_CO_CTL        8'h0c
`define OFS_INT_STATUS    8'h10
`define OFS_INT_MASK      8'h14
`define PWR_FAST_EN       2
`define PWR_SLOW_EN       3
`define PWR_PD_REQ        7
`define PWR_MASK          32'h0000_008c
`define PWR_RST           32'h0000_0004
`define ST_PD             0
`define ST_SLOW_STB       3
`define ST_FAST_STB       4
`define SEL0_SYS_LSB      0
`define SEL0_TICK_LSB     3
`define SEL0_MASK         32'h0000_003f
`define SEL0_RST          32'h0000_0000
`define SRC_FAST          3'h0
`define SRC_SLOW          3'h3
`define CO_N_LSB          0
`define CO_EN             4
`define CO_DIV1           5
`define CO_MASK           32'h0000_003f
`define CO_RST            32'h0000_0000
`define DIV_STAGES        16
`define EV_FAST_STB       0
`define EV_SLOW_STB       1
`define EV_PD_ENTRY       2
`define EV_WAKE           3
`define EV_W              4
`endif

/* File: hw/chip_clk_pkg.sv */
package chip_clk_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
  typedef enum logic {PM_RUN, PM_DOWN} pm_state_type;
endpackage : chip_clk_pkg

/* File: hw/chip_clock_controller.sv */
`timescale 1ns/1ps
`include "chip_clk_consts.svh"
module chip_clock_controller #(
  parameter int FAST_STB_CYC = `FAST_STB_CYC_DEF,
  parameter int SLOW_STB_CYC = `SLOW_STB_CYC_DEF
) (
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  chip_clk_pkg::apb_req_type APB_REQ,
  output chip_clk_pkg::apb_rsp_type APB_RSP,
  input  wire logic                WFI_EXEC,
  input  wire logic                WAKE_IRQ,
  input  wire logic                TICK_EXT_SEL,
  input  wire logic                FAST_OSC_CLK,
  input  wire logic                SLOW_OSC_CLK,
  output logic                     FAST_OSC_EN,
  output logic                     SLOW_OSC_EN,
  output logic                     SYS_CLK_RUN,
  output logic                     SYS_SRC_SLOW,
  output logic                     TICK_CLK_RUN,
  output logic                     TICK_SRC_SLOW,
  output logic                     FAST_PERIPH_RUN,
  output logic                     SLOW_PERIPH_RUN,
  output logic                     POWER_DOWN,
  output logic                     CLK_OUT,
  output logic                     IRQ
);
  import chip_clk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  localparam int CW = `STB_CNT_W;

  if (FAST_STB_CYC < 1 || FAST_STB_CYC >= (1 << CW)) begin : g_chk_fast
    $error("fast stable count out of range");
  end
  if (SLOW_STB_CYC < 1 || SLOW_STB_CYC >= (1 << CW)) begin : g_chk_slow
    $error("slow stable count out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic [31:0]  pwr_r;
  logic [31:0]  pwr_nxt;
  logic [31:0]  sel0_r;
  logic [31:0]  sel0_nxt;
  logic [31:0]  co_r;
  logic [31:0]  co_nxt;
  logic [`EV_W-1:0] ist_r;
  logic [`EV_W-1:0] ist_nxt;
  logic [`EV_W-1:0] imsk_r;
  logic [`EV_W-1:0] imsk_nxt;
  logic [`EV_W-1:0] ev;
  logic [31:0]  rdata_r;
  logic         err_r;
  logic [31:0]  rd_mux;
  logic [31:0]  status_word;

  wire setup_ph = APB_REQ.psel & ~APB_REQ.penable;
  wire access   = APB_REQ.psel & APB_REQ.penable;
  wire wr       = access & APB_REQ.pwrite;
  wire rd       = access & ~APB_REQ.pwrite;

  wire hit_pwr  = APB_REQ.paddr == `OFS_PWR;
  wire hit_st   = APB_REQ.paddr == `OFS_STATUS;
  wire hit_sel0 = APB_REQ.paddr == `OFS_SEL0;
  wire hit_co   = APB_REQ.paddr == `OFS_CO_CTL;
  wire hit_ist  = APB_REQ.paddr == `OFS_INT_STATUS;
  wire hit_imsk = APB_REQ.paddr == `OFS_INT_MASK;
  wire hit_any  = hit_pwr | hit_st | hit_sel0 | hit_co | hit_ist | hit_imsk;

  always_comb begin
    if (hit_pwr) begin
      rd_mux = pwr_r;
    end else if (hit_st) begin
      rd_mux = status_word;
    end else if (hit_sel0) begin
      rd_mux = sel0_r;
    end else if (hit_co) begin
      rd_mux = co_r;
    end else if (hit_ist) begin
      rd_mux = {{(32-`EV_W){1'b0}}, ist_r};
    end else if (hit_imsk) begin
      rd_mux = {{(32-`EV_W){1'b0}}, imsk_r};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  assign APB_RSP.pready  = access;
  assign APB_RSP.pslverr = access & err_r;
  assign APB_RSP.prdata  = rdata_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else if (setup_ph) begin
      rdata_r <= rd_mux;
      err_r   <= ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down state machine

  pm_state_type state_r;
  pm_state_type state_nxt;

  wire pd_req = pwr_r[`PWR_PD_REQ];
  wire in_pd  = state_r == PM_DOWN;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PM_RUN: begin
        if (pd_req && WFI_EXEC) begin // R1
          state_nxt = PM_DOWN;
        end
      end
      PM_DOWN: begin
        if (WAKE_IRQ) begin // R2
          state_nxt = PM_RUN;
        end
      end
      default: state_nxt = PM_RUN;
    endcase
  end

  wire pd_entry = (state_r == PM_RUN) & (state_nxt == PM_DOWN);
  wire wake     = in_pd & (state_nxt == PM_RUN);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= PM_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_comb begin
    pwr_nxt = pwr_r;
    if (wr && hit_pwr) begin
      pwr_nxt = APB_REQ.pwdata & `PWR_MASK;
    end
    if (wake) begin
      pwr_nxt[`PWR_PD_REQ] = 1'b0;
    end
  end

  assign sel0_nxt = (wr && hit_sel0) ? (APB_REQ.pwdata & `SEL0_MASK) : sel0_r;
  assign co_nxt   = (wr && hit_co) ? (APB_REQ.pwdata & `CO_MASK) : co_r;
  assign imsk_nxt = (wr && hit_imsk) ? APB_REQ.pwdata[`EV_W-1:0] : imsk_r;

  // read clears only the bits that were returned; new events win
  wire [`EV_W-1:0] ist_clr = (rd && hit_ist) ? rdata_r[`EV_W-1:0] : '0;
  assign ist_nxt = (ist_r & ~ist_clr) | ev;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pwr_r  <= `PWR_RST;
      sel0_r <= `SEL0_RST;
      co_r   <= `CO_RST;
      ist_r  <= '0;
      imsk_r <= '0;
    end else begin
      pwr_r  <= pwr_nxt;
      sel0_r <= sel0_nxt;
      co_r   <= co_nxt;
      ist_r  <= ist_nxt;
      imsk_r <= imsk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator enables and stable counters

  logic [1:0] osc_en;
  logic [1:0] osc_stb;
  logic [1:0] osc_stb_q;

  // index 0 is the fast oscillator, index 1 the slow one
  assign osc_en[0] = pwr_r[`PWR_FAST_EN] & ~in_pd; // R3 R4
  assign osc_en[1] = pwr_r[`PWR_SLOW_EN];          // R4 R11

  genvar g;
  for (g = 0; g < 2; g++) begin : g_osc
    localparam int STB = (g == 0) ? FAST_STB_CYC : SLOW_STB_CYC;
    localparam logic [CW-1:0] LAST = CW'(STB - 1);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          stb_r;
    logic          stb_nxt;

    assign cnt_nxt = !osc_en[g] ? '0 :                  // R7
                     (cnt_r == LAST) ? cnt_r : cnt_r + 1'b1; // R5
    assign stb_nxt = osc_en[g] & (cnt_r == LAST);       // R5 R7

    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        cnt_r <= '0;
        stb_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        stb_r <= stb_nxt;
      end
    end
    assign osc_stb[g] = stb_r;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_stb_q <= 2'b00;
    end else begin
      osc_stb_q <= osc_stb;
    end
  end

  // status fields placed by their named positions; reserved bits read zero
  always_comb begin
    status_word               = 32'h0000_0000;
    status_word[`ST_PD]       = in_pd;
    status_word[`ST_SLOW_STB] = osc_stb[1]; // R8
    status_word[`ST_FAST_STB] = osc_stb[0]; // R8
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  assign ev[`EV_FAST_STB] = osc_stb[0] & ~osc_stb_q[0];
  assign ev[`EV_SLOW_STB] = osc_stb[1] & ~osc_stb_q[1];
  assign ev[`EV_PD_ENTRY] = pd_entry;
  assign ev[`EV_WAKE]     = wake;

  ////////////////////////////////////////////////////////////////////////////
  // system and tick source selection

  logic sys_slow_r;
  logic sys_slow_nxt;
  logic tick_slow_r;
  logic tick_slow_nxt;

  wire [2:0] sys_sel  = sel0_r[`SEL0_SYS_LSB +: 3];  // R9
  wire [2:0] tick_sel = sel0_r[`SEL0_TICK_LSB +: 3]; // R10

  // a new source is only taken once it is stable
  assign sys_slow_nxt =
    (sys_sel == `SRC_SLOW && osc_stb[1]) ? 1'b1 :
    (sys_sel == `SRC_FAST && osc_stb[0]) ? 1'b0 : sys_slow_r; // R18 R6
  assign tick_slow_nxt =
    (tick_sel == `SRC_SLOW && osc_stb[1]) ? 1'b1 :
    (tick_sel == `SRC_FAST && osc_stb[0]) ? 1'b0 : tick_slow_r; // R10 R6

  wire sys_stb  = sys_slow_r ? osc_stb[1] : osc_stb[0];
  wire tick_stb = tick_slow_r ? osc_stb[1] : osc_stb[0];

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sys_slow_r  <= 1'b0;
      tick_slow_r <= 1'b0;
    end else begin
      sys_slow_r  <= sys_slow_nxt;
      tick_slow_r <= tick_slow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator input synchronisers

  logic [1:0] fast_sync_r;
  logic [1:0] slow_sync_r;
  logic       src_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fast_sync_r <= 2'b00;
      slow_sync_r <= 2'b00;
    end else begin
      fast_sync_r <= {fast_sync_r[0], FAST_OSC_CLK};
      slow_sync_r <= {slow_sync_r[0], SLOW_OSC_CLK};
    end
  end

  wire src_lvl  = sys_slow_r ? slow_sync_r[1] : fast_sync_r[1];
  wire src_rise = src_lvl & ~src_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock output divider

  logic [`DIV_STAGES-1:0] div_r;
  logic [`DIV_STAGES-1:0] div_nxt;
  logic                   run_r;
  logic                   run_nxt;
  logic                   co_out_r;
  logic                   co_out_nxt;

  wire [3:0] div_n   = co_r[`CO_N_LSB +: 4];
  wire       co_en   = co_r[`CO_EN];
  wire       co_div1 = co_r[`CO_DIV1];
  wire       div_sel = div_r[div_n]; // R12 R13
  wire       src_ok  = sys_stb & ~in_pd;
  wire       stop_ok = co_div1 ? ~src_lvl : ~div_sel;

  always_comb begin
    run_nxt = run_r;
    if (in_pd) begin
      run_nxt = 1'b0; // R17
    end else if (co_en) begin
      run_nxt = 1'b1; // R14
    end else if (run_r && stop_ok) begin
      run_nxt = 1'b0; // R15
    end
  end

  // bit k of the counter runs at the source rate over 2^(k+1), toggling every 2^k source rises
  assign div_nxt = !run_r ? '0 :
                   (src_rise && src_ok) ? div_r + 1'b1 : div_r; // R12 R13

  assign co_out_nxt = run_r & ~in_pd & src_ok &
                      (co_div1 ? src_lvl : div_sel); // R16 R15 R17

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      src_q    <= 1'b0;
      div_r    <= '0;
      run_r    <= 1'b0;
      co_out_r <= 1'b0;
    end else begin
      src_q    <= src_lvl;
      div_r    <= div_nxt;
      run_r    <= run_nxt;
      co_out_r <= co_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_OSC_EN     <= 1'b0;
      SLOW_OSC_EN     <= 1'b0;
      SYS_CLK_RUN     <= 1'b0;
      SYS_SRC_SLOW    <= 1'b0;
      TICK_CLK_RUN    <= 1'b0;
      TICK_SRC_SLOW   <= 1'b0;
      FAST_PERIPH_RUN <= 1'b0;
      SLOW_PERIPH_RUN <= 1'b0;
      POWER_DOWN      <= 1'b0;
      IRQ             <= 1'b0;
    end else begin
      FAST_OSC_EN     <= osc_en[0];                          // R3
      SLOW_OSC_EN     <= osc_en[1];                          // R11
      SYS_CLK_RUN     <= sys_stb & ~in_pd;                   // R6 R11
      SYS_SRC_SLOW    <= sys_slow_r;                         // R9
      TICK_CLK_RUN    <= TICK_EXT_SEL & tick_stb & ~in_pd;   // R10 R6
      TICK_SRC_SLOW   <= tick_slow_r;                        // R10
      FAST_PERIPH_RUN <= osc_stb[0] & ~in_pd;                // R6 R11
      SLOW_PERIPH_RUN <= osc_stb[1];                         // R11
      POWER_DOWN      <= in_pd;                              // R2
      IRQ             <= |(ist_nxt & imsk_nxt);
    end
  end

  assign CLK_OUT = co_out_r;

endmodule : chip_clock_controller

/* File: verification/chip_clock_controller_properties.sv */
`timescale 1ns/1ps
module chip_clock_controller_properties #(
  parameter int FAST_STB_CYC = 4
) (
  input wire logic                 CLK,
  input wire logic                 RESET_N,
  input chip_clk_pkg::apb_req_type APB_REQ,
  input chip_clk_pkg::apb_rsp_type APB_RSP,
  input wire logic                 WFI_EXEC,
  input wire logic                 WAKE_IRQ,
  input wire logic                 FAST_OSC_EN,
  input wire logic                 SYS_CLK_RUN,
  input wire logic                 FAST_PERIPH_RUN,
  input wire logic                 POWER_DOWN,
  input wire logic                 CLK_OUT
);
  import chip_clk_pkg::*;
  int en_cnt_r;
  int en_cnt_nxt;
  assign en_cnt_nxt = !FAST_OSC_EN ? 0 : (en_cnt_r < 1000) ? en_cnt_r + 1 : en_cnt_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) en_cnt_r <= 0;
    else en_cnt_r <= en_cnt_nxt;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_wake;
    POWER_DOWN && WAKE_IRQ;
  endsequence
  sequence s_fast_off;
    !FAST_OSC_EN [*3];
  endsequence
  property p_ready;
    APB_REQ.psel && APB_REQ.penable |-> APB_RSP.pready;
  endproperty
  property p_pd_entry;
    $rose(POWER_DOWN) |-> $past(WFI_EXEC, 2);
  endproperty
  property p_pd_leave;
    s_wake |-> ##[1:2] !POWER_DOWN;
  endproperty
  property p_pd_stay;
    $fell(POWER_DOWN) |-> $past(WAKE_IRQ, 2);
  endproperty
  property p_fast_off;
    POWER_DOWN |-> !FAST_OSC_EN;
  endproperty
  property p_gated;
    POWER_DOWN |-> !SYS_CLK_RUN && !FAST_PERIPH_RUN;
  endproperty
  property p_unused;
    s_fast_off |-> !FAST_PERIPH_RUN;
  endproperty
  property p_stable_wait;
    FAST_PERIPH_RUN |-> en_cnt_r >= FAST_STB_CYC;
  endproperty
  property p_out_quiet;
    POWER_DOWN |-> !CLK_OUT;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  a_pd_entry: assert property (p_pd_entry) else $error("power-down without wfi");
  a_pd_leave: assert property (p_pd_leave) else $error("wake ignored");
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without wake");
  a_fast_off: assert property (p_fast_off) else $error("fast osc on in power-down");
  a_gated: assert property (p_gated) else $error("clocks running in power-down");
  a_unused: assert property (p_unused) else $error("fast clock used while off");
  a_stable_wait: assert property (p_stable_wait) else $error("fast used too early");
  a_out_quiet: assert property (p_out_quiet) else $error("clock out in power-down");
endmodule : chip_clock_controller_properties

/* File: verification/osc_model.sv */
`timescale 1ns/1ps
module osc_model #(
  parameter int FAST_HALF_NS = 21,
  parameter int SLOW_HALF_NS = 500
) (
  input  wire logic FAST_OSC_EN,
  input  wire logic SLOW_OSC_EN,
  output logic      FAST_OSC_CLK,
  output logic      SLOW_OSC_CLK
);
  // oscillators stand still low while disabled
  initial FAST_OSC_CLK = 1'b0;
  initial SLOW_OSC_CLK = 1'b0;
  always #(FAST_HALF_NS) FAST_OSC_CLK = FAST_OSC_EN ? ~FAST_OSC_CLK : 1'b0;
  always #(SLOW_HALF_NS) SLOW_OSC_CLK = SLOW_OSC_EN ? ~SLOW_OSC_CLK : 1'b0;
endmodule : osc_model

/* File: verification/chip_clock_controller_test.sv */
`timescale 1ns/1ps
`include "chip_clk_consts.svh"
module chip_clock_controller_test;
  import chip_clk_pkg::*;
  localparam int FSTB = 8;
  localparam int SSTB = 6;
  logic        clk, reset_n, wfi_exec, wake_irq, tick_ext_sel, fast_osc_clk, slow_osc_clk;
  logic        fast_osc_en, slow_osc_en, sys_clk_run, sys_src_slow, tick_clk_run;
  logic        tick_src_slow, fast_periph_run, slow_periph_run, power_down, clk_out, irq;
  apb_req_type apb_req;
  apb_rsp_type apb_rsp;
  logic [31:0] rd;
  logic        err;
  int          bad_count, comparisons, n;
  chip_clock_controller #(.FAST_STB_CYC(FSTB), .SLOW_STB_CYC(SSTB)) i_chip_clock_controller (
    .CLK(clk), .RESET_N(reset_n), .APB_REQ(apb_req), .APB_RSP(apb_rsp), .WFI_EXEC(wfi_exec),
    .WAKE_IRQ(wake_irq), .TICK_EXT_SEL(tick_ext_sel), .FAST_OSC_CLK(fast_osc_clk),
    .SLOW_OSC_CLK(slow_osc_clk), .FAST_OSC_EN(fast_osc_en), .SLOW_OSC_EN(slow_osc_en),
    .SYS_CLK_RUN(sys_clk_run), .SYS_SRC_SLOW(sys_src_slow), .TICK_CLK_RUN(tick_clk_run),
    .TICK_SRC_SLOW(tick_src_slow), .FAST_PERIPH_RUN(fast_periph_run),
    .SLOW_PERIPH_RUN(slow_periph_run), .POWER_DOWN(power_down), .CLK_OUT(clk_out), .IRQ(irq));
  osc_model i_osc_model (.FAST_OSC_EN(fast_osc_en), .SLOW_OSC_EN(slow_osc_en),
    .FAST_OSC_CLK(fast_osc_clk), .SLOW_OSC_CLK(slow_osc_clk));
  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  task chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (apb_rsp.pready !== 1'b1 && k < 16);
    if (apb_rsp.pready !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t bus timeout", $time);
      test_done();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task pulse(input logic wait_for_interrupt_instr);
    @(posedge clk);
    if (wait_for_interrupt_instr) wfi_exec <= 1'b1;
    else wake_irq <= 1'b1;
    @(posedge clk);
    wfi_exec <= 1'b0;
    wake_irq <= 1'b0;
  endtask : pulse
  task rises;
    logic prev;
    n = 0;
    prev = clk_out;
    repeat (269) begin
      @(posedge clk);
      if (clk_out && !prev) n++;
      prev = clk_out;
    end
  endtask : rises
  ////////////////////////////////////////////////////////////////
  task t_reset;
    rdchk(`OFS_PWR, 32'h04);
    repeat (FSTB + 4) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h10);
    chk_bit(irq, 1'b0);
    rdchk(`OFS_INT_STATUS, 32'h01);
    rdchk(`OFS_INT_STATUS, 32'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk_bit(err, 1'b1);
    chk(rd, 32'h0000_0000);
  endtask : t_reset
  task t_select;
    apb(1'b1, `OFS_PWR, 32'h0c);
    repeat (SSTB + 4) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h18);
    tick_ext_sel <= 1'b1;
    apb(1'b1, `OFS_SEL0, 32'h1b);
    repeat (3) @(posedge clk);
    chk_bit(sys_src_slow, 1'b1);
    chk({tick_clk_run, tick_src_slow}, 2'b11);
    apb(1'b1, `OFS_SEL0, 32'h00);
    repeat (3) @(posedge clk);
    chk({sys_src_slow, tick_src_slow}, 2'b00);
    apb(1'b1, `OFS_PWR, 32'h04);
    repeat (3) @(posedge clk);
    rdchk(`OFS_STATUS, 32'h10);
    apb(1'b1, `OFS_SEL0, 32'h03);
    repeat (SSTB + 4) @(posedge clk);
    chk({sys_src_slow, sys_clk_run}, 2'b01);
    apb(1'b1, `OFS_PWR, 32'h0c);
    repeat (SSTB + 4) @(posedge clk);
    chk_bit(sys_src_slow, 1'b1);
    apb(1'b1, `OFS_SEL0, 32'h00);
    repeat (4) @(posedge clk);
  endtask : t_select
  task t_clkout;
    int exp;
    for (int i = 0; i < 4; i++) begin
      exp = (i == 3) ? 64 : 64 >> (i + 1);
      apb(1'b1, `OFS_CO_CTL, (i == 3) ? 32'h30 : 32'h10 + i);
      repeat (20) @(posedge clk);
      rises();
      chk_rng(n, exp - 2, exp + 2);
    end
    apb(1'b1, `OFS_CO_CTL, 32'h13);
    repeat (40) @(posedge clk);
    apb(1'b1, `OFS_CO_CTL, 32'h03);
    repeat (80) @(posedge clk);
    rises();
    chk_rng(n, 0, 0);
    chk_bit(clk_out, 1'b0);
  endtask : t_clkout
  task t_pd;
    apb(1'b1, `OFS_INT_MASK, 32'h0c);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    apb(1'b1, `OFS_CO_CTL, 32'h10);
    pulse(1'b1);
    repeat (4) @(posedge clk);
    chk_bit(power_down, 1'b0);
    apb(1'b1, `OFS_PWR, 32'h8c);
    repeat (4) @(posedge clk);
    chk_bit(power_down, 1'b0);
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk({power_down, fast_osc_en, irq}, 3'b101);
    chk({sys_clk_run, fast_periph_run, slow_periph_run, slow_osc_en}, 4'b0011);
    rises();
    chk_rng(n, 0, 0);
    rdchk(`OFS_STATUS, 32'h09);
    chk_bit(power_down, 1'b1);
    pulse(1'b0);
    repeat (3) @(posedge clk);
    chk_bit(power_down, 1'b0);
    rdchk(`OFS_PWR, 32'h0c);
    apb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk(rd & 32'h0c, 32'h0c);
    repeat (2) @(posedge clk);
    chk_bit(irq, 1'b0);
  endtask : t_pd
  ////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    $display("ERROR %0t run timeout", $time);
    test_done();
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    apb_req = '0;
    wfi_exec = 1'b0;
    wake_irq = 1'b0;
    tick_ext_sel = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_select();
    t_clkout();
    t_pd();
    test_done();
  end
endmodule : chip_clock_controller_test
bind chip_clock_controller chip_clock_controller_properties #(.FAST_STB_CYC(FAST_STB_CYC))
  i_chip_clock_controller_properties (.CLK(CLK), .RESET_N(RESET_N), .APB_REQ(APB_REQ),
  .APB_RSP(APB_RSP), .WFI_EXEC(WFI_EXEC), .WAKE_IRQ(WAKE_IRQ), .FAST_OSC_EN(FAST_OSC_EN),
  .SYS_CLK_RUN(SYS_CLK_RUN), .FAST_PERIPH_RUN(FAST_PERIPH_RUN), .POWER_DOWN(POWER_DOWN),
  .CLK_OUT(CLK_OUT));
